// File: design/gls_pkg.sv
// gls_pkg: constants, types and register map for the gpio global configuration block
package gls_pkg;
  // register offsets
  localparam logic [7:0] ADDR_LS_EN = 8'h3c;
  localparam logic [7:0] ADDR_GLOBAL = 8'h40;
  localparam logic [7:0] ADDR_COMMON_PWM = 8'h45;
  localparam logic [7:0] ADDR_TO_FLAG = 8'h48;
  localparam logic [7:0] ADDR_RANGE_LO = 8'h31;
  localparam logic [7:0] ADDR_RANGE_HI = 8'h5b;
  // global control field positions
  localparam int BIT_TO_IE = 5;
  localparam int BIT_GPIO_EN = 4;
  localparam int BIT_GPIO_RST = 3;
  localparam int FADE_MSB = 2;
  localparam int BIT_TO_FLAG = 0;
  // reset values
  localparam logic [7:0] LS_EN_RST = 8'h00;
  localparam logic [7:0] PWM_RST = 8'h00;
  localparam logic [2:0] FADE_RST = 3'h0;
  localparam logic [7:0] RDATA_NONE = 8'h00;
  // fade codes and ramp shape
  localparam logic [2:0] FADE_OFF = 3'h0;
  localparam logic [2:0] FADE_ONE = 3'h1;
  localparam logic [2:0] FADE_MAX = 3'h5;
  localparam int FADE_STEPS = 16;
  localparam logic [4:0] LEVEL_ZERO = 5'h00;
  localparam logic [4:0] LEVEL_ONE = 5'h01;
  localparam logic [4:0] LEVEL_FULL = 5'h10;
  // timing: shortest total ramp and the clock rate
  localparam int CLK_KHZ = 200000;
  localparam int FADE_MIN_TOTAL_MS = 256;
  localparam int FADE_BASE_CYCLES = FADE_MIN_TOTAL_MS * CLK_KHZ / FADE_STEPS;
  // fade sequencer states
  typedef enum logic [1:0] {
    FADE_HOLD = 2'b00,
    FADE_UP = 2'b01,
    FADE_DOWN = 2'b10
  } gls_fade_state_t;
  // one decoded register access from the serial bus engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gls_req_t;
endpackage

// File: design/gls_global_config.sv
// gls_global_config: level-translator enables, gpio global control, fade ramp and timeout alert
module gls_global_config import gls_pkg::*; #(
  parameter logic [31:0] FADE_BASE = 32'(FADE_BASE_CYCLES)
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register access from the serial bus engine
  input wire gls_req_t req,
  output logic [7:0] rdata,
  // events and levels from the rest of the device
  input wire logic i2c_timeout,
  input wire logic key_sleep,
  input wire logic [7:0] dir2,
  input wire logic led_request,
  // level translator steering
  output logic [7:0] ls_col_to_row,
  output logic [7:0] ls_row_to_col,
  // power and enable controls
  output logic pwm_enable,
  output logic ccs_enable,
  output logic gpi_enable,
  output logic gpo_enable,
  output logic chip_shutdown,
  output logic gpio_soft_reset,
  // led drive
  output logic [7:0] led_duty,
  output logic fade_active,
  // host alert, open drain
  output logic alert_out,
  output logic alert_oe_n
);
  logic [7:0] ls_en_reg, ls_en_next; // translator pair enables
  logic to_ie_reg, to_ie_next; // timeout alert enable
  logic gpio_en_reg, gpio_en_next; // gpio section enable
  logic rst_bit_reg, rst_bit_next; // momentary gpio reset
  logic [2:0] fade_reg, fade_next; // fade time code
  logic [7:0] pwm_reg, pwm_next; // common pwm value
  logic flag_reg, flag_next; // timeout flag
  logic [7:0] rdata_reg, rdata_next; // read data
  gls_fade_state_t state_reg, state_next; // fade sequencer
  logic [4:0] level_reg, level_next; // ramp level 0..16
  logic [31:0] cnt_reg, cnt_next; // cycles within a step
  logic [7:0] duty_reg, duty_next; // led duty output

  // address decode
  wire in_range = (req.addr >= ADDR_RANGE_LO) && (req.addr <= ADDR_RANGE_HI);
  wire is_glb = req.addr == ADDR_GLOBAL;
  // unmapped offsets decode to nothing, so their writes fall away
  // locked writes
  // the global register stays writable, else the section could never be re-enabled
  wire wr_ok = req.wr && (gpio_en_reg || !in_range || is_glb);
  wire wr_ls = wr_ok && (req.addr == ADDR_LS_EN);
  wire wr_glb = wr_ok && is_glb;
  wire wr_pwm = wr_ok && (req.addr == ADDR_COMMON_PWM);
  wire rd_flag = req.rd && (req.addr == ADDR_TO_FLAG);

  // register next values; the soft reset cycle overrides a same-cycle write
  // range reset
  assign ls_en_next = rst_bit_reg ? LS_EN_RST : (wr_ls ? req.wdata : ls_en_reg);
  assign pwm_next = rst_bit_reg ? PWM_RST : (wr_pwm ? req.wdata : pwm_reg);
  assign to_ie_next = rst_bit_reg ? 1'b0 : (wr_glb ? req.wdata[BIT_TO_IE] : to_ie_reg);
  assign gpio_en_next = rst_bit_reg ? 1'b0 : (wr_glb ? req.wdata[BIT_GPIO_EN] : gpio_en_reg);
  assign fade_next = rst_bit_reg ? FADE_RST : (wr_glb ? req.wdata[FADE_MSB:0] : fade_reg);
  assign rst_bit_next = wr_glb && req.wdata[BIT_GPIO_RST] && !rst_bit_reg;
  // clear on read
  // a timeout in the clearing cycle wins, so no event is lost
  // the soft reset clears the flag too, as it sits inside the gpio range
  assign flag_next = i2c_timeout || (flag_reg && !rd_flag && !rst_bit_reg);

  // read mux; unmapped offsets read zero
  // reads stay live while the section is disabled, so state can be inspected
  wire [7:0] glb_view = {2'b00, to_ie_reg, gpio_en_reg, rst_bit_reg, fade_reg};
  assign rdata_next = !req.rd ? rdata_reg :
                      (req.addr == ADDR_LS_EN) ? ls_en_reg :
                      is_glb ? glb_view :
                      (req.addr == ADDR_COMMON_PWM) ? pwm_reg :
                      rd_flag ? {7'h00, flag_reg} : RDATA_NONE;

  assign ls_col_to_row = ls_en_reg & dir2;
  assign ls_row_to_col = ls_en_reg & ~dir2;
  assign pwm_enable = gpio_en_reg;
  assign ccs_enable = gpio_en_reg;
  assign gpi_enable = gpio_en_reg;
  assign chip_shutdown = !gpio_en_reg && key_sleep;
  assign gpo_enable = !chip_shutdown;
  assign gpio_soft_reset = rst_bit_reg;
  // host alert
  // open drain: the data bit is tied low and only the enable moves
  assign alert_out = 1'b0;
  assign alert_oe_n = !(to_ie_reg && flag_reg);

  // fade timing: step length doubles per code
  // undefined codes
  // codes 6 and 7 are clamped to the longest ramp so the counter stays bounded
  wire [2:0] eff_code = (fade_reg > FADE_MAX) ? FADE_MAX : fade_reg;
  wire [2:0] shift_amt = (eff_code == FADE_OFF) ? 3'h0 : eff_code - FADE_ONE;
  wire [31:0] step_len = FADE_BASE << shift_amt;
  // compare with >= so a shorter code picked mid-step ends that step at once
  // instead of letting the counter run on toward wrap-around
  wire step_done = cnt_reg >= (step_len - 32'h1);
  wire target = led_request && gpio_en_reg;
  wire at_full = level_reg == LEVEL_FULL;
  wire at_zero = level_reg == LEVEL_ZERO;

  // fade sequencer: reverses mid-ramp when the request flips
  // sixteen steps
  always_comb begin
    state_next = state_reg;
    level_next = level_reg;
    cnt_next = 32'h0;
    if (fade_reg == FADE_OFF) begin
      state_next = FADE_HOLD;
      level_next = target ? LEVEL_FULL : LEVEL_ZERO;
    end else begin
      unique case (state_reg)
        // idle at either end until the target moves
        FADE_HOLD: begin
          if (target && !at_full) begin
            state_next = FADE_UP;
          end else if (!target && !at_zero) begin
            state_next = FADE_DOWN;
          end
        end
        // rising ramp, one level per step
        FADE_UP: begin
          if (!target) begin
            // reverse at once; the step counter restarts
            state_next = FADE_DOWN;
          end else if (at_full) begin
            // a reversal can land here already at the top: never step past it
            state_next = FADE_HOLD;
          end else if (step_done) begin
            level_next = level_reg + LEVEL_ONE;
            if (level_next == LEVEL_FULL) begin
              state_next = FADE_HOLD;
            end
          end else begin
            cnt_next = cnt_reg + 32'h1;
          end
        end
        // falling ramp, one level per step
        FADE_DOWN: begin
          if (target) begin
            // reverse at once; the step counter restarts
            state_next = FADE_UP;
          end else if (at_zero) begin
            // a reversal can land here already at zero: never step below it
            state_next = FADE_HOLD;
          end else if (step_done) begin
            level_next = level_reg - LEVEL_ONE;
            if (level_next == LEVEL_ZERO) begin
              state_next = FADE_HOLD;
            end
          end else begin
            cnt_next = cnt_reg + 32'h1;
          end
        end
        // the unused state code parks the sequencer
        default: begin
          state_next = FADE_HOLD;
        end
      endcase
    end
  end

  // duty = common pwm scaled by level/16; zero while pwm is shut down
  // the product needs 12 bits at most: 255 times a level of 16
  wire [12:0] scaled = 13'(pwm_reg) * 13'(level_reg);
  assign duty_next = pwm_enable ? scaled[11:4] : 8'h00;
  assign led_duty = duty_reg;
  assign fade_active = state_reg != FADE_HOLD;
  assign rdata = rdata_reg;

  // register state
  // the reset branch loads constants only
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ls_en_reg <= LS_EN_RST;
      pwm_reg <= PWM_RST;
      to_ie_reg <= 1'b0;
      gpio_en_reg <= 1'b0;
      fade_reg <= FADE_RST;
      rst_bit_reg <= 1'b0;
      flag_reg <= 1'b0;
      rdata_reg <= RDATA_NONE;
    end else begin
      ls_en_reg <= ls_en_next;
      pwm_reg <= pwm_next;
      to_ie_reg <= to_ie_next;
      gpio_en_reg <= gpio_en_next;
      fade_reg <= fade_next;
      rst_bit_reg <= rst_bit_next;
      flag_reg <= flag_next;
      rdata_reg <= rdata_next;
    end
  end

  // fade state
  // 32 bits of step count cover the slowest code even at the full clock rate
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= FADE_HOLD;
      level_reg <= LEVEL_ZERO;
      cnt_reg <= 32'h0;
      duty_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      level_reg <= level_next;
      cnt_reg <= cnt_next;
      duty_reg <= duty_next;
    end
  end

  // checks
  // one clock domain: every check shares mclk and sleeps through reset
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // soft reset: the accepting write, one cycle of pulse, then defaults
  sequence s_reset_write;
    wr_glb && req.wdata[BIT_GPIO_RST] && !rst_bit_reg;
  endsequence
  sequence s_reset_done;
    rst_bit_reg ##1 (!rst_bit_reg && ls_en_reg == LS_EN_RST && !gpio_en_reg);
  endsequence

  a_alert_on_timeout: assert property (
    (i2c_timeout && to_ie_next) |=> !alert_oe_n) else $error("alert not asserted");
  a_alert_read_release: assert property (
    (rd_flag && !i2c_timeout && !rst_bit_reg) |=> alert_oe_n) else $error("alert held");
  a_flag_read_clear: assert property (
    (rd_flag && flag_reg && !i2c_timeout) |=> !flag_reg ##0 $past(req.rd))
    else $error("flag not cleared");
  a_locked_range: assert property (
    (req.wr && !gpio_en_reg && req.addr == ADDR_LS_EN && !rst_bit_reg) |=> $stable(ls_en_reg))
    else $error("write accepted while disabled");
  a_ls_write: assert property (
    (wr_ls && !rst_bit_reg) |=> ls_col_to_row == ($past(req.wdata) & dir2))
    else $error("pair link wrong");
  a_duty_shutdown: assert property (
    (!gpio_en_reg) [*2] |-> led_duty == 8'h00) else $error("duty while disabled");
  a_gpo_keep: assert property (
    (!gpio_en_reg && !key_sleep) |-> gpo_enable && !pwm_enable) else $error("gpo dropped");
  a_enable_awake: assert property (
    gpio_en_reg |-> !chip_shutdown && gpo_enable && gpi_enable) else $error("shut down");
  a_reset_pulse: assert property (
    s_reset_write |=> s_reset_done) else $error("soft reset wrong");
  a_reset_momentary: assert property (
    rst_bit_reg |=> !rst_bit_reg) else $error("reset bit stuck");
  a_fade_unit_step: assert property (
    (fade_reg != FADE_OFF && $stable(fade_reg) && level_reg != $past(level_reg)) |->
      (level_reg == $past(level_reg) + LEVEL_ONE || level_reg == $past(level_reg) - LEVEL_ONE))
    else $error("fade jumped");
  a_fade_off_jump: assert property (
    (fade_reg == FADE_OFF && target) |=> level_reg == LEVEL_FULL) else $error("no jump");
  a_step_bound: assert property (
    $stable(fade_reg) |-> cnt_reg < step_len) else $error("step overran");
  a_step_len_code: assert property (
    (eff_code == FADE_MAX) |-> step_len == (FADE_BASE << 4)) else $error("ramp length");
  a_level_bound: assert property (
    level_reg <= LEVEL_FULL) else $error("ramp level past full");
  a_reverse_ramp: assert property (
    (state_reg == FADE_UP && !target && fade_reg != FADE_OFF) |=> state_reg == FADE_DOWN)
    else $error("ramp did not reverse");
  a_sleep_shutdown: assert property (
    (!gpio_en_reg && key_sleep) |-> chip_shutdown && !gpo_enable) else $error("not shut");
  a_flag_set_wins: assert property (
    i2c_timeout |=> flag_reg) else $error("timeout flag lost");
  a_section_off: assert property (
    !gpio_en_reg |-> !pwm_enable && !ccs_enable && !gpi_enable) else $error("section on");
  a_pair_one_way: assert property (
    (ls_col_to_row & ls_row_to_col) == 8'h00 && (ls_col_to_row | ls_row_to_col) == ls_en_reg)
    else $error("pair link wrong");
  a_jump_to_zero: assert property (
    (fade_reg == FADE_OFF && !target) |=> level_reg == LEVEL_ZERO) else $error("no drop");
  a_step_even: assert property (
    (fade_reg != FADE_OFF && state_reg == FADE_UP && target && !at_full && !step_done)
      |=> level_reg == $past(level_reg)) else $error("step came early");
endmodule // gls_global_config

// File: verif/gls_host.sv
// gls_host: host-side model that issues decoded register accesses to the block
module gls_host import gls_pkg::*; (
  // clock
  input wire logic mclk,
  // access port toward the device
  output gls_req_t req,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle request at time zero
  initial req = '0;
  // one write; the strobe is held over exactly one taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    // released lines show the inverse, so stale values never look valid
    #1 req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // one read; data is taken once the accepting edge has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    #1 req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
    d = rdata;
  endtask
  // fade codes above the last defined one are never sent
  task automatic set_global(input logic ie, input logic en, input logic [2:0] fade);
    wr(ADDR_GLOBAL, {2'b00, ie, en, 1'b0, (fade > FADE_MAX) ? FADE_MAX : fade});
  endtask
endmodule // gls_host

// File: verif/testbench.sv
// testbench: self-checking bench for the gpio global configuration block
module testbench import gls_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  // short step length keeps every ramp to at most 1026 cycles
  localparam logic [31:0] BASE = 32'h4;
  logic mclk, rst, i2c_timeout, key_sleep, led_request;
  logic [7:0] dir2, rdata, c2r, r2c, led_duty, d, v;
  logic pwm_en, ccs_en, gpi_en, gpo_en, shut, srst, fade_act, alert_out, alert_oe_n;
  gls_req_t req;
  int miscompares = 0, n_tests = 0, n, e;
  logic [7:0] ra [4] = '{ADDR_LS_EN, ADDR_GLOBAL, ADDR_COMMON_PWM, ADDR_TO_FLAG};
  // device under test
  gls_global_config #(.FADE_BASE(BASE)) DUT (.mclk(mclk), .rst(rst), .req(req),
    .rdata(rdata), .i2c_timeout(i2c_timeout), .key_sleep(key_sleep), .dir2(dir2),
    .led_request(led_request), .ls_col_to_row(c2r), .ls_row_to_col(r2c),
    .pwm_enable(pwm_en), .ccs_enable(ccs_en), .gpi_enable(gpi_en), .gpo_enable(gpo_en),
    .chip_shutdown(shut), .gpio_soft_reset(srst), .led_duty(led_duty),
    .fade_active(fade_act), .alert_out(alert_out), .alert_oe_n(alert_oe_n));
  // host partner
  gls_host HOST (.mclk(mclk), .req(req), .rdata(rdata));
  // free-running clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // compare one value, counting every check
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // verdict and end of run
  task automatic summarize();
    $display("checks=%0d miscompares=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one-cycle bus timeout pulse
  task automatic pulse();
    i2c_timeout = 1'b1;
    @(posedge mclk);
    #1 i2c_timeout = 1'b0;
  endtask
  // cycles until the duty reaches the target, bounded
  task automatic meas(input logic [7:0] t);
    n = 0;
    while (led_duty !== t && n < 3000) begin
      @(posedge mclk);
      #1 n++;
    end
  endtask
  // expected ramp length: code zero jumps, others take sixteen equal steps
  function automatic int ramp_cycles(input int c);
    return (c == 0) ? 2 : 16 * (int'(BASE) << (c - 1)) + 2;
  endfunction
  // hang guard, far beyond the longest expected run
  initial begin
    #200000;
    miscompares++;
    summarize();
  end
  // main sequence
  initial begin
    rst = 1'b1;
    i2c_timeout = 1'b0;
    key_sleep = 1'b0;
    dir2 = 8'h00;
    led_request = 1'b0;
    void'($urandom(32'h26311437));
    repeat (5) @(posedge mclk);
    #1 rst = 1'b0;
    foreach (ra[i]) begin
      HOST.rd(ra[i], d);
      cmp(d, 0);
    end
    // disabled: range writes dropped, sleep shuts the whole part
    key_sleep = 1'b1;
    HOST.wr(ADDR_LS_EN, 8'($urandom) | 8'h01);
    HOST.rd(ADDR_LS_EN, d);
    cmp(d, 0);
    cmp({shut, gpo_en, pwm_en, ccs_en, gpi_en}, 5'b10000);
    HOST.set_global(1'b0, 1'b1, 3'h0);
    cmp({shut, gpo_en, pwm_en, ccs_en, gpi_en}, 5'b01111);
    key_sleep = 1'b0;
    // random translator pairs and directions
    repeat (6) begin
      v = 8'($urandom);
      dir2 = 8'($urandom);
      HOST.wr(ADDR_LS_EN, v);
      cmp(c2r, v & dir2);
      cmp(r2c, v & ~dir2);
      HOST.rd(ADDR_LS_EN, d);
      cmp(d, v);
    end
    // alert asserted only when enabled, flag cleared by its read
    HOST.set_global(1'b1, 1'b1, 3'h0);
    pulse();
    cmp(alert_oe_n, 0);
    cmp(alert_out, 0);
    HOST.rd(ADDR_TO_FLAG, d);
    cmp(d, 1);
    cmp(alert_oe_n, 1);
    HOST.rd(ADDR_TO_FLAG, d);
    cmp(d, 0);
    HOST.set_global(1'b0, 1'b1, 3'h0);
    pulse();
    cmp(alert_oe_n, 1);
    HOST.rd(ADDR_TO_FLAG, d);
    cmp(d, 1);
    // each defined fade code 0 to 5, up then down, against the total ramp time
    v = 8'($urandom) | 8'h10;
    HOST.wr(ADDR_COMMON_PWM, v);
    for (int c = 0; c <= 5; c++) begin
      HOST.set_global(1'b0, 1'b1, 3'(c));
      e = ramp_cycles(c);
      led_request = 1'b1;
      meas(v);
      cmp(n, e);
      cmp(fade_act, 0);
      led_request = 1'b0;
      meas(8'h00);
      cmp(n, e);
      cmp(fade_act, 0);
    end
    // reversal right after a ramp starts must settle at zero, never wrap
    led_request = 1'b1;
    repeat (2) @(posedge mclk);
    #1 cmp(fade_act, 1);
    led_request = 1'b0;
    repeat (2) @(posedge mclk);
    #1 cmp({fade_act, led_duty}, 0);
    // self-clearing reset of the range
    HOST.wr(ADDR_LS_EN, 8'h5a);
    HOST.wr(ADDR_GLOBAL, 8'h18);
    cmp(srst, 1);
    @(posedge mclk);
    #1 cmp(srst, 0);
    HOST.rd(ADDR_GLOBAL, d);
    cmp(d, 0);
    HOST.rd(ADDR_LS_EN, d);
    cmp(d, 0);
    // gpio now disabled: no drive even with a request
    led_request = 1'b1;
    repeat (3) @(posedge mclk);
    #1 cmp({pwm_en, led_duty}, 0);
    summarize();
  end
endmodule // testbench
